// ---- pkg/vfdms_pkg.sv ----
package vfdms_pkg;

    // Panel geometry and serial word
    localparam int VFDMS_SEGS      = 56;
    localparam int VFDMS_WORD_BITS = 64;
    localparam int VFDMS_FIFO_DEEP = 8;

    // Word fields: kind in the top two bits, payload below
    localparam int VFDMS_KIND_LSB = 62;
    localparam int VFDMS_DUTY_LSB = 0;
    localparam int VFDMS_DIM_BITS = 10;

    // Dimming timing: one bit time is four oscillator periods
    localparam int VFDMS_OSC_PER_BIT   = 4;
    localparam int VFDMS_BITS_PER_SLOT = 1024;

    // Reset values
    localparam logic [9:0] VFDMS_DUTY_RST = 10'h000;
    localparam logic [2:0] VFDMS_GRID_RST = 3'h6;

    // Grid phase, also the code on the phase-align pins
    typedef enum logic [1:0] {
        VFDMS_G1 = 2'b00,
        VFDMS_G2 = 2'b01,
        VFDMS_G3 = 2'b10
    } vfdms_grid_t;

    // Word kinds: grid data for grids 1..3, or dimming duty
    localparam logic [1:0] VFDMS_KIND_DIM = 2'h3;

    typedef struct packed {
        logic [1:0]  kind;
        logic [61:0] payload;
    } vfdms_word_t;

    // Phase carried between generator and output stage
    typedef struct packed {
        logic        dim;
        vfdms_grid_t grid;
    } vfdms_phase_t;

endpackage

// ---- src/vfdms_top.sv ----
`timescale 1ns/1ps

module vfdms_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [CW-1:0]    cnt_reg;
    logic             push;
    logic             pop;

    // Honest flags straight from the fill count
    assign in_ready_o  = (cnt_reg != CW'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o  = mem_reg[rd_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Storage has no reset; only pointers and count need one
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data_i;
        end
    end

    // Pointers and count
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= AW'(wr_reg + 1'b1);
            end
            if (pop) begin
                rd_reg <= AW'(rd_reg + 1'b1);
            end
            if (push && !pop) begin
                cnt_reg <= CW'(cnt_reg + 1'b1);
            end else if (pop && !push) begin
                cnt_reg <= CW'(cnt_reg - 1'b1);
            end
        end
    end
endmodule

module vfdms_top
    import vfdms_pkg::*;
#(
    parameter int SEGS      = VFDMS_SEGS,
    parameter int WORD_BITS = VFDMS_WORD_BITS,
    parameter int FIFO_DEEP = VFDMS_FIFO_DEEP
) (
    // Oscillator clock and reset
    input  wire logic            mclk_i,
    input  wire logic            rst_n_i,
    // Serial host link
    input  wire logic            sclk_i,
    input  wire logic            cs_i,
    input  wire logic            sdata_i,
    // Static straps
    input  wire logic            duty_select_i,
    input  wire logic            master_sel_i,
    // Slave-side inputs from a master
    input  wire logic            dimming_pulse_input_i,
    input  wire logic            phase_align_input_a_i,
    input  wire logic            phase_align_input_b_i,
    // Master-side outputs to a slave
    output logic                 dimming_pulse_output_o,
    output logic                 phase_align_output_a_o,
    output logic                 phase_align_output_b_o,
    // Display drive; bit 0 is the first grid output
    output logic [2:0]           grid_n_o,
    output logic [SEGS-1:0]      anode_segment_outputs_o
);
    localparam int BW = $clog2(WORD_BITS);

    // Link clock domain
    logic                 link_rst_n_reg;
    logic                 sclk_clr_n;
    logic [BW-1:0]        bit_cnt_reg;
    logic [WORD_BITS-1:0] shift_reg;
    logic [WORD_BITS-1:0] word_hold_reg;
    logic                 word_tog_reg;

    // Link side released one clock after the core reset
    always_ff @(posedge mclk_i) begin
        link_rst_n_reg <= rst_n_i;
    end

    assign sclk_clr_n = cs_i && link_rst_n_reg;

    // Bit counter and shifter; shift clock may stop between frames
    always_ff @(posedge sclk_i or negedge sclk_clr_n) begin
        if (!sclk_clr_n) begin
            bit_cnt_reg <= '0;
            shift_reg   <= '0;
        end else begin
            shift_reg <= {shift_reg[WORD_BITS-2:0], sdata_i};
            if (bit_cnt_reg == BW'(WORD_BITS - 1)) begin
                bit_cnt_reg <= '0;
            end else begin
                bit_cnt_reg <= BW'(bit_cnt_reg + 1'b1);
            end
        end
    end

    // Whole word held stable and announced by a toggle
    always_ff @(posedge sclk_i or negedge link_rst_n_reg) begin
        if (!link_rst_n_reg) begin
            word_hold_reg <= '0;
            word_tog_reg  <= 1'b0;
        end else if (cs_i && bit_cnt_reg == BW'(WORD_BITS - 1)) begin
            word_hold_reg <= {shift_reg[WORD_BITS-2:0], sdata_i};
            word_tog_reg  <= ~word_tog_reg;
        end
    end

    // Oscillator domain: input synchronisers
    logic [2:0] tog_sync_reg;
    logic [2:0] cs_sync_reg;
    logic [1:0] duty_sync_reg;
    logic [1:0] role_sync_reg;
    logic [1:0] dim_sync_reg;
    logic [1:0] pa_a_sync_reg;
    logic [1:0] pa_b_sync_reg;
    logic       word_arrive;
    logic       cs_fall;
    logic       is_duplex;
    logic       is_master;

    // Two flops on every foreign input, a third for edges
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tog_sync_reg  <= '0;
            cs_sync_reg   <= '0;
            duty_sync_reg <= '0;
            role_sync_reg <= '0;
            dim_sync_reg  <= '0;
            pa_a_sync_reg <= '0;
            pa_b_sync_reg <= '0;
        end else begin
            tog_sync_reg  <= {tog_sync_reg[1:0], word_tog_reg};
            cs_sync_reg   <= {cs_sync_reg[1:0], cs_i};
            duty_sync_reg <= {duty_sync_reg[0], duty_select_i};
            role_sync_reg <= {role_sync_reg[0], master_sel_i};
            dim_sync_reg  <= {dim_sync_reg[0], dimming_pulse_input_i};
            pa_a_sync_reg <= {pa_a_sync_reg[0], phase_align_input_a_i};
            pa_b_sync_reg <= {pa_b_sync_reg[0], phase_align_input_b_i};
        end
    end

    assign word_arrive = tog_sync_reg[2] ^ tog_sync_reg[1];
    assign cs_fall     = cs_sync_reg[2] && !cs_sync_reg[1];
    assign is_duplex   = duty_sync_reg[1];
    assign is_master   = role_sync_reg[1];

    // Word capture and buffering
    logic                 hold_valid_reg;
    logic [WORD_BITS-1:0] hold_data_reg;
    logic                 fifo_in_ready;
    logic                 fifo_out_valid;
    logic                 bit_tick;
    logic [WORD_BITS-1:0] fifo_out_data;
    vfdms_word_t          pop_word;

    // Hold one word until the FIFO takes it; arrival wins over accept.
    // A word arriving while one still waits overwrites it.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            hold_valid_reg <= 1'b0;
            hold_data_reg  <= '0;
        end else if (word_arrive) begin
            hold_valid_reg <= 1'b1;
            hold_data_reg  <= word_hold_reg;
        end else if (fifo_in_ready) begin
            hold_valid_reg <= 1'b0;
        end
    end

    // Drained once per bit time, so bursts really fill it
    vfdms_fifo #(
        .WIDTH (WORD_BITS),
        .DEPTH (FIFO_DEEP)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (hold_valid_reg),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (hold_data_reg),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (bit_tick),
        .out_data_o  (fifo_out_data)
    );

    assign pop_word = vfdms_word_t'(fifo_out_data[63:0]);

    // Staging and display latches
    logic [SEGS-1:0] stage_seg_reg [3];
    logic [SEGS-1:0] disp_seg_reg  [3];
    logic [9:0]      stage_duty_reg;
    logic [9:0]      duty_reg;
    logic            commit_pend_reg;
    logic            commit_now;

    // Commit only once everything shifted before deselect has landed
    assign commit_now = commit_pend_reg && !fifo_out_valid
                        && !hold_valid_reg && !word_arrive;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            commit_pend_reg <= 1'b0;
        end else begin
            commit_pend_reg <= cs_fall || (commit_pend_reg && !commit_now);
        end
    end

    // Staging takes popped words; display only sees a whole update
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            stage_seg_reg  <= '{default: '0};
            disp_seg_reg   <= '{default: '0};
            stage_duty_reg <= VFDMS_DUTY_RST;
            duty_reg       <= VFDMS_DUTY_RST;
        end else begin
            if (fifo_out_valid && bit_tick) begin
                if (pop_word.kind == VFDMS_KIND_DIM) begin
                    stage_duty_reg <= pop_word.payload[VFDMS_DIM_BITS-1:0];
                end else begin
                    stage_seg_reg[pop_word.kind] <= pop_word.payload[SEGS-1:0];
                end
            end
            if (commit_now) begin
                disp_seg_reg <= stage_seg_reg;
                duty_reg     <= stage_duty_reg;
            end
        end
    end

    // Internal timing generator
    logic [1:0]  pre_reg;
    logic [9:0]  slot_bit_reg;
    vfdms_grid_t grid_reg;
    vfdms_grid_t last_grid;
    logic        dim_m_reg;
    logic        slot_end;

    assign bit_tick  = (pre_reg == 2'(VFDMS_OSC_PER_BIT - 1));
    assign last_grid = is_duplex ? VFDMS_G2 : VFDMS_G3;
    // Last bit time of a grid slot
    assign slot_end  = bit_tick
                       && slot_bit_reg == 10'(VFDMS_BITS_PER_SLOT - 1);

    // Prescaler and bit position within a grid slot
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pre_reg      <= '0;
            slot_bit_reg <= '0;
        end else begin
            pre_reg <= 2'(pre_reg + 1'b1);
            if (bit_tick) begin
                slot_bit_reg <= 10'(slot_bit_reg + 1'b1);
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            grid_reg <= VFDMS_G1;
        end else if (slot_end) begin
            if (grid_reg == last_grid || grid_reg == VFDMS_G3) begin
                grid_reg <= VFDMS_G1;
            end else begin
                grid_reg <= vfdms_grid_t'(2'(grid_reg + 1'b1));
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            dim_m_reg <= 1'b0;
        end else begin
            dim_m_reg <= (slot_bit_reg < duty_reg);
        end
    end

    // Output stage
    vfdms_phase_t phase;

    always_comb begin
        if (is_master) begin
            phase.dim  = dim_m_reg;
            phase.grid = grid_reg;
        end else begin
            phase.dim  = dim_sync_reg[1];
            phase.grid = vfdms_grid_t'({pa_b_sync_reg[1], pa_a_sync_reg[1]});
        end
    end

    // Segments gated by the dimming pulse of the active grid
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            anode_segment_outputs_o <= '0;
        end else if (phase.dim && phase.grid != 2'h3) begin
            anode_segment_outputs_o <= disp_seg_reg[phase.grid];
        end else begin
            anode_segment_outputs_o <= '0;
        end
    end

    for (genvar g = 0; g < 3; g++) begin : g_grid
        always_ff @(posedge mclk_i) begin
            if (!rst_n_i) begin
                grid_n_o[g] <= VFDMS_GRID_RST[g];
            end else begin
                grid_n_o[g] <= (phase.grid != 2'(g));
            end
        end
    end

    // Own timing always offered to a slave, whatever our role
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            dimming_pulse_output_o <= 1'b0;
            phase_align_output_a_o <= 1'b0;
            phase_align_output_b_o <= 1'b0;
        end else begin
            dimming_pulse_output_o <= dim_m_reg;
            phase_align_output_a_o <= grid_reg[0];
            phase_align_output_b_o <= grid_reg[1];
        end
    end

    // Assertions
    property p_cs_low_idle;
        @(posedge sclk_i) disable iff (!link_rst_n_reg)
        !cs_i |-> bit_cnt_reg == '0 ##1 $stable(word_tog_reg);
    endproperty
    a_cs_low_idle: assert property (p_cs_low_idle)
        else $error("word taken or counted while deselected");

    property p_shift_in;
        @(posedge sclk_i) disable iff (!link_rst_n_reg)
        cs_i && bit_cnt_reg != '0 |-> shift_reg[0] == $past(sdata_i);
    endproperty
    a_shift_in: assert property (p_shift_in)
        else $error("shifted bit differs from data pin");

    property p_duplex_two;
        @(posedge mclk_i) disable iff (!rst_n_i)
        is_duplex && grid_reg == VFDMS_G2 && bit_tick
        && slot_bit_reg == 10'h3FF |=> grid_reg == VFDMS_G1;
    endproperty
    a_duplex_two: assert property (p_duplex_two)
        else $error("duplex did not wrap after second grid");

    property p_triplex_three;
        @(posedge mclk_i) disable iff (!rst_n_i)
        !is_duplex && grid_reg == VFDMS_G2 && bit_tick
        && slot_bit_reg == 10'h3FF |=> grid_reg == VFDMS_G3;
    endproperty
    a_triplex_three: assert property (p_triplex_three)
        else $error("triplex skipped third grid");

    property p_slave_dim;
        @(posedge mclk_i) disable iff (!rst_n_i)
        !is_master && !dim_sync_reg[1] |=> anode_segment_outputs_o == '0;
    endproperty
    a_slave_dim: assert property (p_slave_dim)
        else $error("slave segment on without dim input");

    property p_master_dim;
        @(posedge mclk_i) disable iff (!rst_n_i)
        is_master && !dim_m_reg |=> anode_segment_outputs_o == '0;
    endproperty
    a_master_dim: assert property (p_master_dim)
        else $error("master segment on outside dim pulse");

    property p_bit_time;
        @(posedge mclk_i) disable iff (!rst_n_i)
        bit_tick |=> !bit_tick [*3] ##1 bit_tick;
    endproperty
    a_bit_time: assert property (p_bit_time)
        else $error("bit time is not four clocks");

    property p_dimming_pulse_output;
        @(posedge mclk_i) disable iff (!rst_n_i)
        dim_m_reg |=> dimming_pulse_output_o;
    endproperty
    a_dimming_pulse_output: assert property (p_dimming_pulse_output)
        else $error("dimming pulse not driven out");

    property p_phase_out;
        @(posedge mclk_i) disable iff (!rst_n_i)
        ##1 {phase_align_output_b_o, phase_align_output_a_o}
            == $past(grid_reg);
    endproperty
    a_phase_out: assert property (p_phase_out)
        else $error("phase-align outputs do not track grid");

    property p_grid_inv;
        @(posedge mclk_i) disable iff (!rst_n_i)
        is_master && grid_reg == VFDMS_G1 |=> !grid_n_o[0] && grid_n_o[1];
    endproperty
    a_grid_inv: assert property (p_grid_inv)
        else $error("first grid not driven low when active");

    property p_commit_only;
        @(posedge mclk_i) disable iff (!rst_n_i)
        !commit_now |=> $stable(duty_reg);
    endproperty
    a_commit_only: assert property (p_commit_only)
        else $error("duty changed outside a commit");

    c_commit: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        commit_now && stage_duty_reg != '0);
    c_fifo_full: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        !fifo_in_ready);
    c_third_grid: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        grid_reg == VFDMS_G3);
    c_slave_seg: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        !is_master && anode_segment_outputs_o != '0);
endmodule

// ---- testbench/vfdms_host_model.sv ----
`timescale 1ns/1ps
// Host controller on the serial link; it makes the shift clock itself
module vfdms_host_model (
    // Serial link towards the device
    output logic sclk_o,
    output logic cs_o,
    output logic sdata_o
);
    // Shift clock stands still outside frames
    initial begin
        sclk_o  = 1'b0;
        cs_o    = 1'b0;
        sdata_o = 1'b0;
    end

    // One 64-bit word, MSB first, 48 ns shift clock period
    task automatic send(input logic [63:0] word, input logic sel);
        // select held over the whole word
        cs_o = sel;
        #24;
        for (int i = 63; i >= 0; i--) begin
            // data valid ahead of the rising edge
            sdata_o = word[i];
            #24 sclk_o = 1'b1;
            #24 sclk_o = 1'b0;
        end
        #24 cs_o = 1'b0;
        // Idle data shows the inverse so a stale bit is never trusted
        sdata_o = ~word[0];
        #300;
    endtask
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import vfdms_pkg::*;

    localparam logic [55:0] PAT = 56'hA50F3C961277E1;

    // Bench-driven inputs
    logic        mclk_i   = 1'b0;
    logic        rst_n_i  = 1'b0;
    logic        duty_sel = 1'b0;
    logic        mst_sel  = 1'b1;
    logic        dimming_pulse_input   = 1'b1;
    logic        pa_in    = 1'b1;
    logic        pb_in    = 1'b1;
    // Link and outputs
    logic        sclk;
    logic        cs;
    logic        sdata;
    logic        dimming_pulse_output;
    logic        pa_out;
    logic        pb_out;
    logic [2:0]  grid_n;
    logic [55:0] seg;
    int          miscompares     = 0;
    int          samples_checked = 0;
    int          c[4];

    // 100 MHz oscillator clock
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end

    vfdms_host_model u_host (
        .sclk_o  (sclk),
        .cs_o    (cs),
        .sdata_o (sdata)
    );

    vfdms_top u_dut (
        .mclk_i                  (mclk_i),
        .rst_n_i                 (rst_n_i),
        .sclk_i                  (sclk),
        .cs_i                    (cs),
        .sdata_i                 (sdata),
        .duty_select_i           (duty_sel),
        .master_sel_i            (mst_sel),
        .dimming_pulse_input_i   (dimming_pulse_input),
        .phase_align_input_a_i   (pa_in),
        .phase_align_input_b_i   (pb_in),
        .dimming_pulse_output_o  (dimming_pulse_output),
        .phase_align_output_a_o  (pa_out),
        .phase_align_output_b_o  (pb_out),
        .grid_n_o                (grid_n),
        .anode_segment_outputs_o (seg)
    );

    task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Straps change at the edge, then the synchronisers settle
    task automatic straps(input logic m, d, di, a, b);
        @(posedge mclk_i);
        mst_sel  <= m;
        duty_sel <= d;
        dimming_pulse_input   <= di;
        pa_in    <= a;
        pb_in    <= b;
        repeat (8) @(posedge mclk_i);
    endtask

    // Counts dim high, pattern shown, phase code v and grid code g
    task automatic count(input int n, input logic [1:0] v,
                         input logic [2:0] g, output int r[4]);
        r = '{default: 0};
        repeat (n) begin
            @(posedge mclk_i);
            #1;
            r[0] += (dimming_pulse_output === 1'b1);
            r[1] += (seg === PAT);
            r[2] += ({pb_out, pa_out} === v);
            r[3] += (grid_n === g);
        end
    endtask

    task automatic send(input logic [63:0] w, input logic sel);
        #2;
        u_host.send(w, sel);
        repeat (40) @(posedge mclk_i);
    endtask

    // Reset values and a blank display afterwards
    task automatic t_reset;
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (16) @(posedge mclk_i);
        #1;
        check("grid", 64'(grid_n), 64'h6);
        check("seg", 64'(seg), 64'h0);
        check("dim", 64'(dimming_pulse_output), 64'h0);
        check("phase", 64'({pb_out, pa_out}), 64'h0);
        @(posedge mclk_i);
        rst_n_i <= 1'b1;
        count(4096, 2'h0, 3'h6, c);
        check("dim count", 64'(c[0]), 64'h0);
        check("seg zero", 64'(c[1]), 64'h0);
    endtask

    // Master triplex, inputs held at odd levels that must not matter
    task automatic t_master;
        int duty[4] = '{1, 64, 1023, 1016};
        straps(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        send({2'h0, 6'h00, PAT}, 1'b1);
        // Word clocked while deselected must leave latches alone
        send({2'h0, 62'h3FFFFFFFFFFFFFFF}, 1'b0);
        foreach (duty[i]) begin
            send({VFDMS_KIND_DIM, 52'h0, 10'(duty[i])}, 1'b1);
            count(12288, 2'h2, 3'h3, c);
            check("dim width", 64'(c[0]), 64'(12 * duty[i]));
            check("seg width", 64'(c[1]), 64'(4 * duty[i]));
            check("code grid3", 64'(c[2]), 64'h1000);
            check("grid3 low", 64'(c[3]), 64'h1000);
        end
    endtask

    // Master duplex: two slots of equal length, no third grid
    task automatic t_duplex;
        straps(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        repeat (4200) @(posedge mclk_i);
        count(8192, 2'h1, 3'h5, c);
        check("dup code", 64'(c[2]), 64'h1000);
        check("dup grid2", 64'(c[3]), 64'h1000);
        check("dup seg", 64'(c[1]), 64'(4 * 1016));
        count(8192, 2'h2, 3'h3, c);
        check("dup no g3", 64'(c[3]), 64'h0);
    endtask

    // Slave follows the phase-align and dimming inputs
    task automatic t_slave;
        for (int i = 0; i < 4; i++) begin
            straps(1'b0, 1'b0, 1'b0, i[0], i[1]);
            count(20, 2'h0, ~(3'h1 << i), c);
            check("slave grid", 64'(c[3]), 64'h14);
        end
        straps(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        fork
            begin
                @(posedge mclk_i);
                dimming_pulse_input <= 1'b1;
                repeat (100) @(posedge mclk_i);
                dimming_pulse_input <= 1'b0;
            end
            count(300, 2'h0, 3'h6, c);
        join
        check("slave width", 64'(c[1]), 64'h64);
    endtask

    // Duty alone after a reset: the cleared latches keep the panel blank
    task automatic t_cleared;
        send({VFDMS_KIND_DIM, 52'h0, 10'h3F8}, 1'b1);
        count(12288, 2'h0, 3'h6, c);
        check("dim after reset", 64'(c[0]), 64'(12 * 1016));
        check("latch cleared", 64'(c[1]), 64'h0);
    endtask

    initial begin
        t_reset();
        t_master();
        t_duplex();
        t_slave();
        straps(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        // Second reset in mid-run clears duty and latches
        t_reset();
        t_cleared();
        report_and_stop();
    end
endmodule
